// ===== hdl/bbs_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbs_defines.svh"

module bbs_exec (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [15:0] instr_word,
    input wire logic overflow_flag,
    input wire logic zero_flag,
    input wire logic [3:0] bank_number_register,
    input wire logic ext_set_enable,
    input wire logic [`BBS_ADDR_W-1:0] index_base_addr,
    input wire logic [7:0] mem_rdata,
    output bbs_pkg::bbs_phase_t phase_q,
    output logic [`BBS_PC_W-1:0] pc_q,
    output logic pc_write_q,
    output logic nop_cycle_q,
    output logic [`BBS_ADDR_W-1:0] mem_addr_q,
    output logic mem_rd_q,
    output logic mem_wr_q,
    output logic [7:0] mem_wdata_q,
    output logic status_write_q
);
    import bbs_pkg::*;

    bbs_op_t op_q;
    logic [15:0] instr_q;
    logic [`BBS_PC_W-1:0] target_q;
    logic [7:0] rdata_q;
    logic taken_q;
    bbs_op_t op_d;
    logic [`BBS_ADDR_W-1:0] addr_d;
    logic [`BBS_PC_W-1:0] short_off;
    logic [`BBS_PC_W-1:0] long_off;
    logic [7:0] bit_mask;

    bbs_phase_gen u_phase (
        .clock(clock),
        .rst_b(rst_b),
        .phase_q(phase_q)
    );

    // Decode of the word presented during the first phase
    always_comb begin
        op_d = OP_OTHER;
        if (instr_word[15:8] == `BBS_OPC_NO_OVF) begin
            op_d = OP_NO_OVF;
        end else if (instr_word[15:8] == `BBS_OPC_NONZERO) begin
            op_d = OP_NONZERO;
        end else if (instr_word[15:11] == `BBS_OPC_REL_JUMP) begin
            op_d = OP_REL_JUMP;
        end else if (instr_word[15:12] == `BBS_OPC_SET_BIT) begin
            op_d = OP_SET_BIT;
        end
    end

    // File address selection for bit set
    always_comb begin
        if (instr_word[8]) begin
            addr_d = {bank_number_register, instr_word[7:0]};
        end else if (ext_set_enable && (instr_word[7:0] <= `BBS_IDX_LIMIT)) begin
            addr_d = index_base_addr + {4'h0, instr_word[7:0]};
        end else if (instr_word[7:0] < `BBS_ACC_SPLIT) begin
            addr_d = {`BBS_ACC_LOW_BANK, instr_word[7:0]};
        end else begin
            addr_d = {`BBS_ACC_HIGH_BANK, instr_word[7:0]};
        end
    end

    // Offsets are doubled by the appended zero
    assign short_off = {{12{instr_q[7]}}, instr_q[7:0], 1'b0};
    assign long_off = {{9{instr_q[10]}}, instr_q[10:0], 1'b0};
    assign bit_mask = 8'h01 << instr_q[11:9];

    // Instruction latch and decode; idle cycle decodes nothing
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            op_q <= OP_OTHER;
            instr_q <= `BBS_INSTR_RESET;
        end else if (phase_q == PH_Q1) begin
            op_q <= nop_cycle_q ? OP_OTHER : op_d;
            instr_q <= instr_word;
        end
    end

    // Branch decision and target in the third phase
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            taken_q <= 1'b0;
            target_q <= `BBS_PC_RESET;
        end else if (phase_q == PH_Q3) begin
            case (op_q)
                OP_NO_OVF: begin
                    taken_q <= !overflow_flag;
                    target_q <= pc_q + short_off;
                end
                OP_NONZERO: begin
                    taken_q <= !zero_flag;
                    target_q <= pc_q + short_off;
                end
                OP_REL_JUMP: begin
                    taken_q <= 1'b1;
                    target_q <= pc_q + long_off;
                end
                default: begin
                    taken_q <= 1'b0;
                    target_q <= pc_q;
                end
            endcase
        end
    end

    // Counter: step on fetch, overwrite in the fourth phase when taken
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= `BBS_PC_RESET;
        end else if (phase_q == PH_Q1 && !nop_cycle_q) begin
            pc_q <= pc_q + `BBS_PC_STEP;
        end else if (phase_q == PH_Q4 && pc_write_q) begin
            pc_q <= target_q;
        end
    end

    // Counter write strobe stands through the fourth phase only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_write_q <= 1'b0;
        end else if (phase_q == PH_Q3) begin
            pc_write_q <= (op_q == OP_NO_OVF && !overflow_flag) ||
                          (op_q == OP_NONZERO && !zero_flag) ||
                          (op_q == OP_REL_JUMP);
        end else begin
            pc_write_q <= 1'b0;
        end
    end

    // Second cycle of a taken branch is a flush
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            nop_cycle_q <= 1'b0;
        end else if (phase_q == PH_Q4) begin
            nop_cycle_q <= pc_write_q;
        end
    end

    // Read-modify-write of the file register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_addr_q <= `BBS_ADDR_RESET;
            mem_rd_q <= 1'b0;
        end else if (phase_q == PH_Q1) begin
            mem_rd_q <= !nop_cycle_q && (op_d == OP_SET_BIT);
            if (!nop_cycle_q && op_d == OP_SET_BIT) begin
                mem_addr_q <= addr_d;
            end
        end else begin
            mem_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= `BBS_DATA_RESET;
        end else if (phase_q == PH_Q2 && mem_rd_q) begin
            rdata_q <= mem_rdata;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_wr_q <= 1'b0;
            mem_wdata_q <= `BBS_DATA_RESET;
        end else if (phase_q == PH_Q3) begin
            mem_wr_q <= (op_q == OP_SET_BIT);
            if (op_q == OP_SET_BIT) begin
                mem_wdata_q <= rdata_q | bit_mask;
            end
        end else begin
            mem_wr_q <= 1'b0;
        end
    end

    // Flags are never written by this group
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            status_write_q <= 1'b0;
        end else begin
            status_write_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    property p_no_ovf_taken;
        (phase_q == PH_Q3 && op_q == OP_NO_OVF) |=> (pc_write_q == !$past(overflow_flag));
    endproperty
    a_no_ovf_taken: assert property (p_no_ovf_taken) else $error("overflow branch decision wrong");

    property p_nonzero_taken;
        (phase_q == PH_Q3 && op_q == OP_NONZERO) |=> (pc_write_q == !$past(zero_flag));
    endproperty
    a_nonzero_taken: assert property (p_nonzero_taken) else $error("zero branch decision wrong");

    property p_short_target;
        (phase_q == PH_Q1 && !nop_cycle_q && instr_word[15:8] == `BBS_OPC_NO_OVF)
            |=> ##2 (target_q == $past(pc_q, 3) + `BBS_PC_STEP
                     + {{12{$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3), 1'b0});
    endproperty
    a_short_target: assert property (p_short_target) else $error("short branch target wrong");

    property p_taken_flush;
        (phase_q == PH_Q4 && pc_write_q) |=> nop_cycle_q [*4] ##1 !nop_cycle_q;
    endproperty
    a_taken_flush: assert property (p_taken_flush) else $error("taken branch flush not one cycle");

    property p_untaken_step;
        (phase_q == PH_Q3 && op_q == OP_NONZERO && zero_flag)
            |=> !pc_write_q ##1 (!nop_cycle_q && pc_q == $past(pc_q, 2));
    endproperty
    a_untaken_step: assert property (p_untaken_step) else $error("untaken branch altered counter");

    property p_rel_jump;
        (phase_q == PH_Q1 && !nop_cycle_q && instr_word[15:11] == `BBS_OPC_REL_JUMP)
            |=> ##2 pc_write_q && (target_q == $past(pc_q, 3) + `BBS_PC_STEP
                + {{9{$past(instr_word[10], 3)}}, $past(instr_word[10:0], 3), 1'b0});
    endproperty
    a_rel_jump: assert property (p_rel_jump) else $error("relative jump target wrong");

    property p_set_rmw;
        (phase_q == PH_Q1 && !nop_cycle_q && instr_word[15:12] == `BBS_OPC_SET_BIT)
            |=> mem_rd_q ##1 !mem_rd_q ##1 (mem_wr_q && mem_wdata_q ==
                ($past(mem_rdata, 2) | (8'h01 << $past(instr_word[11:9], 3))));
    endproperty
    a_set_rmw: assert property (p_set_rmw) else $error("bit set read-modify-write wrong");

    property p_bank_select;
        (phase_q == PH_Q1 && !nop_cycle_q && instr_word[15:12] == `BBS_OPC_SET_BIT && instr_word[8])
            |=> (mem_addr_q == {$past(bank_number_register), $past(instr_word[7:0])});
    endproperty
    a_bank_select: assert property (p_bank_select) else $error("banked address wrong");

    property p_indexed;
        (phase_q == PH_Q1 && !nop_cycle_q && instr_word[15:12] == `BBS_OPC_SET_BIT && !instr_word[8]
         && ext_set_enable && instr_word[7:0] <= `BBS_IDX_LIMIT)
            |=> (mem_addr_q == $past(index_base_addr) + {4'h0, $past(instr_word[7:0])});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_no_status;
        !status_write_q;
    endproperty
    a_no_status: assert property (p_no_status) else $error("status written");

    // Flush cycle must leave the file and the counter alone
    property p_flush_quiet;
        nop_cycle_q |-> (!mem_rd_q && !mem_wr_q && !pc_write_q);
    endproperty
    a_flush_quiet: assert property (p_flush_quiet) else $error("strobe raised in flush cycle");

    property p_flush_holds_pc;
        nop_cycle_q |=> $stable(pc_q);
    endproperty
    a_flush_holds_pc: assert property (p_flush_holds_pc) else $error("counter moved in flush cycle");

    property p_untaken_no_flush;
        (phase_q == PH_Q4 && !pc_write_q) |=> !nop_cycle_q;
    endproperty
    a_untaken_no_flush: assert property (p_untaken_no_flush) else $error("flush after untaken cycle");

    property p_jump_always;
        (phase_q == PH_Q3 && op_q == OP_REL_JUMP) |=> pc_write_q;
    endproperty
    a_jump_always: assert property (p_jump_always) else $error("relative jump not taken");

    property p_pc_step;
        (phase_q == PH_Q1 && !nop_cycle_q) |=> (pc_q == $past(pc_q) + `BBS_PC_STEP);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter did not step one word");

    // Bit set is a data operation only, it never redirects the counter
    property p_set_no_branch;
        (phase_q == PH_Q3 && op_q == OP_SET_BIT) |=> !pc_write_q;
    endproperty
    a_set_no_branch: assert property (p_set_no_branch) else $error("bit set wrote the counter");

    c_taken: cover property (phase_q == PH_Q4 && pc_write_q && op_q == OP_NO_OVF);
    c_flush: cover property (nop_cycle_q && phase_q == PH_Q4);
    c_untaken: cover property (phase_q == PH_Q3 && op_q == OP_NONZERO && zero_flag);
    c_jump: cover property (phase_q == PH_Q4 && pc_write_q && op_q == OP_REL_JUMP);
    c_set: cover property (mem_wr_q && mem_wdata_q != rdata_q);

endmodule // bbs_exec

`default_nettype wire

// ===== hdl/bbs_defines.svh
`ifndef BBS_DEFINES_SVH
`define BBS_DEFINES_SVH

// Upper-byte and upper-field opcodes
`define BBS_OPC_NO_OVF 8'hE5
`define BBS_OPC_NONZERO 8'hE1
`define BBS_OPC_REL_JUMP 5'h1A
`define BBS_OPC_SET_BIT 4'h8

// Widths
`define BBS_PC_W 21
`define BBS_ADDR_W 12

// Program counter step per program word, in bytes
`define BBS_PC_STEP 21'h000002

// Reset values
`define BBS_PC_RESET 21'h000000
`define BBS_ADDR_RESET 12'h000
`define BBS_DATA_RESET 8'h00
`define BBS_INSTR_RESET 16'h0000

// Access bank layout and indexed-offset window
`define BBS_ACC_SPLIT 8'h80
`define BBS_ACC_LOW_BANK 4'h0
`define BBS_ACC_HIGH_BANK 4'hF
`define BBS_IDX_LIMIT 8'h5F

`endif

// ===== hdl/bbs_pkg.sv
package bbs_pkg;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } bbs_phase_t;

    typedef enum logic [2:0] {
        OP_OTHER,
        OP_NO_OVF,
        OP_NONZERO,
        OP_REL_JUMP,
        OP_SET_BIT
    } bbs_op_t;

endpackage

// ===== hdl/bbs_phase_gen.sv
`timescale 1ns/10ps
`default_nettype none

module bbs_phase_gen (
    input wire logic clock,
    input wire logic rst_b,
    output bbs_pkg::bbs_phase_t phase_q
);
    import bbs_pkg::*;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= PH_Q1;
        end else begin
            case (phase_q)
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: phase_q <= PH_Q1;
                default: phase_q <= PH_Q1;
            endcase
        end
    end

endmodule // bbs_phase_gen

`default_nettype wire

// ===== test/bbs_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbs_defines.svh"
`define BBS_CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module bbs_exec_tb;
    import bbs_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] instr_word = 16'hF000;
    logic overflow_flag = 1'b0;
    logic zero_flag = 1'b0;
    logic [3:0] bank_number_register = 4'h0;
    logic ext_set_enable = 1'b0;
    logic [`BBS_ADDR_W-1:0] index_base_addr = 12'h300;
    logic [7:0] mem_rdata = 8'h00;
    bbs_phase_t phase_q;
    logic [`BBS_PC_W-1:0] pc_q;
    logic pc_write_q;
    logic nop_cycle_q;
    logic [`BBS_ADDR_W-1:0] mem_addr_q;
    logic mem_rd_q;
    logic mem_wr_q;
    logic [7:0] mem_wdata_q;
    logic status_write_q;
    int n_errors = 0;
    int check_count = 0;
    // First word after reset is a non-block opcode, so only the step shows
    logic [`BBS_PC_W-1:0] exp_pc = 21'h000002;

    bbs_exec u_bbs_exec (
        .clock(clock),
        .rst_b(rst_b),
        .instr_word(instr_word),
        .overflow_flag(overflow_flag),
        .zero_flag(zero_flag),
        .bank_number_register(bank_number_register),
        .ext_set_enable(ext_set_enable),
        .index_base_addr(index_base_addr),
        .mem_rdata(mem_rdata),
        .phase_q(phase_q),
        .pc_q(pc_q),
        .pc_write_q(pc_write_q),
        .nop_cycle_q(nop_cycle_q),
        .mem_addr_q(mem_addr_q),
        .mem_rd_q(mem_rd_q),
        .mem_wr_q(mem_wr_q),
        .mem_wdata_q(mem_wdata_q),
        .status_write_q(status_write_q)
    );

    always #12.5 clock = ~clock;

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Runs one instruction from its take edge to its last cycle, checking Q1, Q2 and Q4 (Q3 is not checked)
    task automatic issue(input logic [15:0] w, input logic ovf = 1'b0, input logic zf = 1'b0,
                         input logic [3:0] bnr = 4'h0, input logic ext = 1'b0, input logic [7:0] rd = 8'h00);
        logic [`BBS_PC_W-1:0] pc0;
        logic [`BBS_PC_W-1:0] off;
        logic [`BBS_PC_W-1:0] tgt;
        logic [`BBS_ADDR_W-1:0] adr;
        logic [7:0] f;
        logic tk;
        logic st;
        int k;
        f = w[7:0];
        st = (w[15:12] == `BBS_OPC_SET_BIT);
        tk = (w[15:8] == `BBS_OPC_NO_OVF && !ovf) || (w[15:8] == `BBS_OPC_NONZERO && !zf)
             || (w[15:11] == `BBS_OPC_REL_JUMP);
        off = (w[15:11] == `BBS_OPC_REL_JUMP) ? 21'($signed(w[10:0])) : 21'($signed(w[7:0]));
        if (w[8]) begin
            adr = {bnr, f};
        end else if (ext && f <= `BBS_IDX_LIMIT) begin
            adr = index_base_addr + {4'h0, f};
        end else if (f < `BBS_ACC_SPLIT) begin
            adr = {`BBS_ACC_LOW_BANK, f};
        end else begin
            adr = {`BBS_ACC_HIGH_BANK, f};
        end
        // Set off the take edge; the design only latches at the end of Q1
        @(posedge clock);
        instr_word <= w;
        overflow_flag <= ovf;
        zero_flag <= zf;
        bank_number_register <= bnr;
        ext_set_enable <= ext;
        mem_rdata <= rd;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (!(phase_q === PH_Q1 && nop_cycle_q === 1'b0) && k < 16);
        if (k >= 16) begin
            n_errors++;
            close_out();
        end
        `BBS_CHK("pc", exp_pc, pc_q)
        pc0 = pc_q;
        tgt = pc0 + `BBS_PC_STEP + (off << 1);
        @(negedge clock);
        `BBS_CHK("phase q2", PH_Q2, phase_q)
        `BBS_CHK("pc step", pc0 + `BBS_PC_STEP, pc_q)
        `BBS_CHK("rd strobe", st, mem_rd_q)
        @(negedge clock);
        @(negedge clock);
        `BBS_CHK("phase q4", PH_Q4, phase_q)
        `BBS_CHK("pc write", tk, pc_write_q)
        `BBS_CHK("wr strobe", st, mem_wr_q)
        `BBS_CHK("status write", 1'b0, status_write_q)
        if (st) begin
            `BBS_CHK("addr", adr, mem_addr_q)
            `BBS_CHK("wdata", rd | (8'h01 << w[11:9]), mem_wdata_q)
        end
        exp_pc = tk ? tgt : pc0 + `BBS_PC_STEP;
        if (tk) begin
            // Stops inside the last flush cycle so the next word is set at the start of Q1, before the end-of-Q1 latch
            repeat (4) begin
                @(negedge clock);
                `BBS_CHK("flush", 1'b1, nop_cycle_q)
                `BBS_CHK("flush pc", tgt, pc_q)
                `BBS_CHK("flush strobes", 2'b00, {pc_write_q, mem_rd_q})
            end
        end
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (19) @(posedge clock);
        @(negedge clock);
        `BBS_CHK("reset pc", 21'h000000, pc_q)
        `BBS_CHK("reset phase", PH_Q1, phase_q)
        `BBS_CHK("reset outs", 4'h0, {pc_write_q, nop_cycle_q, mem_rd_q, mem_wr_q})
        `BBS_CHK("reset addr", 20'h00000, {mem_addr_q, mem_wdata_q})
        @(posedge clock);
        rst_b <= 1'b1;
        issue(16'hE57F, 1'b0, 1'b1);
        issue(16'hE580, 1'b1, 1'b0);
        issue(16'hE580, 1'b0, 1'b0);
        issue(16'hE105, 1'b1, 1'b0);
        issue(16'hE105, 1'b0, 1'b1);
        issue(16'hD3FF, 1'b1, 1'b1);
        issue(16'hD400, 1'b1, 1'b1);
        issue(16'hE67F);
        issue(16'h8F12, 1'b0, 1'b0, 4'h5, 1'b0, 8'h0A);
        issue(16'h8A5F, 1'b0, 1'b0, 4'h5, 1'b1, 8'h00);
        issue(16'h8060, 1'b0, 1'b0, 4'h5, 1'b1, 8'h80);
        issue(16'h8610, 1'b0, 1'b0, 4'h5, 1'b0, 8'h00);
        issue(16'h8C80, 1'b0, 1'b0, 4'h5, 1'b1, 8'h3F);
        issue(16'hF000);
        close_out();
    end
endmodule // bbs_exec_tb

`undef BBS_CHK
`default_nettype wire
